// *** design/edge_if.sv ***
// Filtered edge pulses from one input filter to the timer core.
// Assumes both ends share aclk; pulses last one aclk cycle.
`timescale 1ns/10ps
`default_nettype none
interface edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface
`default_nettype wire

// *** design/timer_consts.svh ***
// Offsets, field positions, reset values and counts for the timer slice.
// Assumes inclusion by bare name; the guard allows repeated inclusion.
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
// Register byte offsets on the AXI4-Lite slave
`define OFS_PRM    8'h00
`define OFS_TMC    8'h04
`define OFS_CRC    8'h08
`define OFS_TOC    8'h0c
`define OFS_CR0    8'h10
`define OFS_CR1    8'h14
`define OFS_CNT    8'h18
`define OFS_STS    8'h1c
`define OFS_MSK    8'h20
// Field positions
`define PRM_CKS_HI 1
`define PRM_CKS_LO 0
`define PRM_ES0_HI 4
`define PRM_ES0_LO 3
`define PRM_ES1_HI 6
`define PRM_ES1_LO 5
`define TMC_OP_HI  3
`define TMC_OP_LO  2
`define CRC_CR0CAP 0
`define CRC_CR0REV 1
`define CRC_CR1SRC 2
`define STS_MATCH0 0
`define STS_CAPT1  1
// Field codes
`define CKS_EXT    2'h3
`define OP_STOP    2'h0
`define OP_CLR_TI0 2'h2
`define OP_CLR_MAT 2'h3
`define ES_FALL    2'h0
`define ES_RISE    2'h1
`define ES_BOTH    2'h3
// Reset values
`define RST_REG8   8'h00
`define RST_REG16  16'h0000
// Sample clock divider: aclk cycles per sample tick
`define PRESCALE_DIV 4
// AXI responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

// *** design/timer_edge_filter.sv ***
// Pin synchroniser and two-sample noise filter for one timer input.
// Assumes pin is asynchronous to aclk and tick comes from the prescaler.
`timescale 1ns/10ps
`default_nettype none
module timer_edge_filter (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic tick,
  input  wire logic pin,
  edge_if.src       edg
);
  timer_pkg::filt_state_t r_ff;
  timer_pkg::filt_state_t nxt_r;

  // ==========================================
  // Sync, sample on tick, accept on two equal samples
  always_comb begin
    nxt_r = r_ff;
    nxt_r.s1   = pin;
    nxt_r.s2   = r_ff.s1;
    nxt_r.rise = 1'b0;
    nxt_r.fall = 1'b0;
    if (tick) begin
      nxt_r.samp = r_ff.s2;
      // Short pulses seen in one sample only never reach lvl
      if (r_ff.samp == r_ff.s2 && r_ff.s2 != r_ff.lvl) begin
        nxt_r.lvl  = r_ff.s2;
        nxt_r.rise = r_ff.s2;
        nxt_r.fall = !r_ff.s2;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) r_ff <= '0;
    else r_ff <= nxt_r;
  end

  assign edg.rise = r_ff.rise;
  assign edg.fall = r_ff.fall;
endmodule // timer_edge_filter
`default_nettype wire

// *** design/timer_event_count_capture.sv ***
// 16-bit timer/event counter with capture, AXI4-Lite register slave.
// Assumes pins are asynchronous to aclk; all else is on aclk.
//
// Notes on behaviour
// - Mode 11/11 counts valid input0 edges
// - Event mode raises match_irq0 on count match
// - Later matches every compare plus one edges
// - First match after compare plus two edges
// - Input0 sampled once per sample tick
// - Edge valid after two equal samples
// - Capture 07H: rise to reg0, fall to reg1
// - Reverse-phase capture gives no match_irq0
// - Input1 edge then raises match_irq0 without capture
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "timer_consts.svh"
module timer_event_count_capture #(
  parameter int PRESCALE = `PRESCALE_DIV
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        event_capture_input0,
  input  wire logic        capture_input1,
  output logic             match_irq0,
  output logic             capture_irq1,
  output logic             irq
);
  timer_pkg::top_state_t r_ff;
  timer_pkg::top_state_t nxt_r;
  logic                  tick;

  // ==========================================
  // Sample tick and input filters
  edge_if e0 ();
  edge_if e1 ();

  timer_prescaler #(
    .DIV (PRESCALE)
  ) u_pre (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  timer_edge_filter u_f0 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick),
    .pin     (event_capture_input0),
    .edg     (e0.src)
  );

  timer_edge_filter u_f1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick),
    .pin     (capture_input1),
    .edg     (e1.src)
  );

  // ==========================================
  // Edge selection helpers
  // Code 10 selects no edge, so software can park an input without gating
  function automatic logic sel_edge(input logic [1:0] es,
                                    input logic rise,
                                    input logic fall);
    logic v;
    v = 1'b0;
    unique case (es)
      `ES_FALL: v = fall;
      `ES_RISE: v = rise;
      `ES_BOTH: v = rise | fall;
      default:  v = 1'b0; // 10 selects no edge
    endcase
    return v;
  endfunction

  // Read data for one register offset
  function automatic logic [31:0] rd_mux(input timer_pkg::top_state_t s,
                                         input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      `OFS_PRM: d = {24'h000000, s.prm};
      `OFS_TMC: d = {24'h000000, s.tmc};
      `OFS_CRC: d = {24'h000000, s.crc};
      `OFS_TOC: d = {24'h000000, s.toc};
      `OFS_CR0: d = {16'h0000, s.cr0};
      `OFS_CR1: d = {16'h0000, s.cr1};
      `OFS_CNT: d = {16'h0000, s.cnt};
      `OFS_STS: d = {30'h0000_0000, s.sts};
      `OFS_MSK: d = {30'h0000_0000, s.msk};
      default:  d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    logic m;
    m = (a == `OFS_PRM) || (a == `OFS_TMC) || (a == `OFS_CRC) ||
        (a == `OFS_TOC) || (a == `OFS_CR0) || (a == `OFS_CR1) ||
        (a == `OFS_CNT) || (a == `OFS_STS) || (a == `OFS_MSK);
    return m;
  endfunction

  // Byte-lane merge for registers up to 16 bits
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  ws);
    logic [15:0] v;
    v = old;
    if (ws[0]) v[7:0] = wd[7:0];
    if (ws[1]) v[15:8] = wd[15:8];
    return v;
  endfunction

  // ==========================================
  // Next-state logic
  always_comb begin
    logic [1:0]  op;
    logic        ext;
    logic        v0;
    logic        rv0;
    logic        v1;
    logic        inc;
    logic        hit;
    logic        cap1;
    logic        do_wr;
    logic [1:0]  clr;
    logic [15:0] wv;
    op    = 2'h0;
    ext   = 1'b0;
    v0    = 1'b0;
    rv0   = 1'b0;
    v1    = 1'b0;
    inc   = 1'b0;
    hit   = 1'b0;
    cap1  = 1'b0;
    do_wr = 1'b0;
    clr   = 2'h0;
    wv    = 16'h0000;
    nxt_r = r_ff;

    op  = r_ff.tmc[`TMC_OP_HI:`TMC_OP_LO];
    ext = r_ff.prm[`PRM_CKS_HI:`PRM_CKS_LO] == `CKS_EXT;
    v0  = sel_edge(r_ff.prm[`PRM_ES0_HI:`PRM_ES0_LO], e0.rise, e0.fall);
    // Reverse phase swaps rise and fall of the input0 edge choice
    rv0 = sel_edge(r_ff.prm[`PRM_ES0_HI:`PRM_ES0_LO], e0.fall, e0.rise);
    v1  = sel_edge(r_ff.prm[`PRM_ES1_HI:`PRM_ES1_LO], e1.rise, e1.fall);

    // Bus: take address and data in either order
    // Readies stay low until the response is taken: one write in flight
    if (s_axi_awvalid && r_ff.awrdy) begin
      nxt_r.aw_got = 1'b1;
      nxt_r.awa    = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && r_ff.wrdy) begin
      nxt_r.w_got = 1'b1;
      nxt_r.wd    = s_axi_wdata;
      nxt_r.ws    = s_axi_wstrb;
    end
    if (r_ff.bvalid && s_axi_bready) nxt_r.bvalid = 1'b0;
    do_wr = r_ff.aw_got && r_ff.w_got && !r_ff.bvalid;

    // Counter and captures run before register writes
    // so a software write to a capture register wins in the same cycle
    if (op == `OP_STOP) begin
      nxt_r.cnt   = 16'h0000;
      nxt_r.armed = 1'b0;
    end else begin
      inc = ext ? v0 : tick;
      // Capture register 1 on the selected input's edge
      if (r_ff.crc[`CRC_CR1SRC] ? v0 : v1) begin
        nxt_r.cr1 = r_ff.cnt;
        cap1      = 1'b1;
      end
      if (r_ff.crc[`CRC_CR0CAP]) begin
        if (r_ff.crc[`CRC_CR0REV]) begin
          if (rv0) nxt_r.cr0 = r_ff.cnt;
          if (v1) hit = 1'b1;
        end else if (v1) begin
          nxt_r.cr0 = r_ff.cnt;
          hit       = 1'b1;
        end
      end
      if (op == `OP_CLR_TI0 && v0 && !ext) begin
        // Clear and start; input0 cannot also be the count source
        nxt_r.cnt = 16'h0000;
      end else if (inc) begin
        if (ext && op == `OP_CLR_MAT && !r_ff.armed) begin
          // First valid edge only starts the counter
          nxt_r.armed = 1'b1;
        end else if (op == `OP_CLR_MAT && r_ff.cnt == r_ff.cr0) begin
          nxt_r.cnt = 16'h0000;
          hit       = !r_ff.crc[`CRC_CR0CAP];
        end else begin
          nxt_r.cnt = r_ff.cnt + 16'h0001;
          if (r_ff.cnt == r_ff.cr0 && !r_ff.crc[`CRC_CR0CAP]) hit = 1'b1;
        end
      end
    end

    // Register writes
    if (do_wr) begin
      nxt_r.aw_got = 1'b0;
      nxt_r.w_got  = 1'b0;
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp  = mapped(r_ff.awa) ? `RESP_OKAY : `RESP_SLVERR;
      wv = merge16(16'h0000, r_ff.wd, r_ff.ws);
      if (r_ff.ws[0]) begin
        unique case (r_ff.awa)
          `OFS_PRM: nxt_r.prm = wv[7:0];
          `OFS_TMC: begin
            nxt_r.tmc = wv[7:0];
            // Writing stop rearms the first-match delay
            if (wv[`TMC_OP_HI:`TMC_OP_LO] == `OP_STOP) nxt_r.armed = 1'b0;
          end
          `OFS_CRC: nxt_r.crc = wv[7:0];
          `OFS_TOC: nxt_r.toc = wv[7:0];
          `OFS_STS: clr = wv[1:0];
          `OFS_MSK: nxt_r.msk = wv[1:0];
          default: ;
        endcase
      end
      if (r_ff.awa == `OFS_CR0) nxt_r.cr0 = merge16(r_ff.cr0, r_ff.wd, r_ff.ws);
      if (r_ff.awa == `OFS_CR1) nxt_r.cr1 = merge16(r_ff.cr1, r_ff.wd, r_ff.ws);
    end

    // Sticky status: a new event wins over a write-one clear
    nxt_r.sts = (r_ff.sts & ~clr) | {cap1, hit};
    nxt_r.m_irq0 = hit;
    nxt_r.c_irq1 = cap1;
    nxt_r.irq    = |(nxt_r.sts & nxt_r.msk);

    // Read channel
    // Data is latched at the address handshake and stands until taken
    if (r_ff.rvalid && s_axi_rready) nxt_r.rvalid = 1'b0;
    if (s_axi_arvalid && r_ff.arrdy) begin
      nxt_r.rvalid = 1'b1;
      nxt_r.rdata  = rd_mux(r_ff, {s_axi_araddr[7:2], 2'b00});
      nxt_r.rresp  = mapped({s_axi_araddr[7:2], 2'b00}) ? `RESP_OKAY
                                                        : `RESP_SLVERR;
    end

    // Ready flags stay registered so every output is a flip-flop
    nxt_r.awrdy = !nxt_r.aw_got && !nxt_r.bvalid;
    nxt_r.wrdy  = !nxt_r.w_got && !nxt_r.bvalid;
    nxt_r.arrdy = !nxt_r.rvalid;
  end

  // ==========================================
  // State register
  // Synchronous reset; the stored registers take their reset values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_ff     <= '0;
      r_ff.prm <= `RST_REG8;
      r_ff.tmc <= `RST_REG8;
      r_ff.cr0 <= `RST_REG16;
      r_ff.cr1 <= `RST_REG16;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // ==========================================
  // Outputs
  // Each output is a plain copy of a state flip-flop
  assign s_axi_awready = r_ff.awrdy;
  assign s_axi_wready  = r_ff.wrdy;
  assign s_axi_bvalid  = r_ff.bvalid;
  assign s_axi_bresp   = r_ff.bresp;
  assign s_axi_arready = r_ff.arrdy;
  assign s_axi_rvalid  = r_ff.rvalid;
  assign s_axi_rdata   = r_ff.rdata;
  assign s_axi_rresp   = r_ff.rresp;
  assign match_irq0    = r_ff.m_irq0;
  assign capture_irq1  = r_ff.c_irq1;
  assign irq           = r_ff.irq;
endmodule // timer_event_count_capture
`default_nettype wire

// *** design/timer_pkg.sv ***
// Types shared by the timer slice modules.
// Assumes the constants header is not needed here; widths are fixed.
package timer_pkg;
  // Top-level state: registers, counter, interrupt and bus slave
  typedef struct packed {
    logic [7:0]  prm;
    logic [7:0]  tmc;
    logic [7:0]  crc;
    logic [7:0]  toc;
    logic [15:0] cr0;
    logic [15:0] cr1;
    logic [15:0] cnt;
    logic        armed;
    logic [1:0]  sts;
    logic [1:0]  msk;
    logic        irq;
    logic        m_irq0;
    logic        c_irq1;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        awrdy;
    logic        wrdy;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } top_state_t;

  // Input filter state
  typedef struct packed {
    logic s1;
    logic s2;
    logic samp;
    logic lvl;
    logic rise;
    logic fall;
  } filt_state_t;

  // Prescaler state
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } pre_state_t;
endpackage

// *** design/timer_prescaler.sv ***
// Sample clock generator: one-cycle tick every DIV aclk cycles.
// Assumes a synchronous active-low reset on aclk.
`timescale 1ns/10ps
`default_nettype none
`include "timer_consts.svh"
module timer_prescaler #(
  parameter int DIV = `PRESCALE_DIV
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      tick
);
  timer_pkg::pre_state_t r_ff;
  timer_pkg::pre_state_t nxt_r;

  // ==========================================
  // Divider
  always_comb begin
    nxt_r = r_ff;
    nxt_r.tick = 1'b0;
    if (r_ff.cnt == 16'(DIV - 1)) begin
      nxt_r.cnt  = 16'h0000;
      nxt_r.tick = 1'b1;
    end else begin
      nxt_r.cnt = r_ff.cnt + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) r_ff <= '0;
    else r_ff <= nxt_r;
  end

  assign tick = r_ff.tick;
endmodule // timer_prescaler
`default_nettype wire

// *** sim/pulse_source.sv ***
// Partner model: digital pulse source on the two timer input pins.
// Assumes the bench calls its task; pins change just after aclk rises.
`timescale 1ns/10ps
`default_nettype none
module pulse_source (
  input  wire logic aclk,
  output logic      pin0,
  output logic      pin1
);
  // =====
  // Pins idle low; a pulse is hi cycles high then lo cycles low
  initial begin
    pin0 = 1'b0;
    pin1 = 1'b0;
  end
  task automatic pulse(input int sel, input int hi, input int lo);
    @(posedge aclk);
    if (sel == 0) pin0 <= 1'b1;
    else pin1 <= 1'b1;
    repeat (hi) @(posedge aclk);
    if (sel == 0) pin0 <= 1'b0;
    else pin1 <= 1'b0;
    repeat (lo) @(posedge aclk);
  endtask
endmodule // pulse_source
`default_nettype wire

// *** sim/timer_event_count_capture_bench.sv ***
// Bench for the timer slice: bus tasks, event count and pulse width.
// Assumes the pulse source drives the pins; a short prescale keeps runs brief.
`include "timer_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module timer_event_count_capture_bench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic        event_capture_input0, capture_input1, match_irq0, capture_irq1;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, got, c0, rs;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [34:0] exp_q[$];
  logic [34:0] e_rd;
  int          err_count, n_checks, n_match, n_capt, n, h;
  // Two aclk cycles per sample tick keep the divider in play
  localparam int PRE = 2;

  timer_event_count_capture #(
    .PRESCALE (PRE)
  ) uut (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .s_axi_awaddr         (s_axi_awaddr),
    .s_axi_awvalid        (s_axi_awvalid),
    .s_axi_awready        (s_axi_awready),
    .s_axi_wdata          (s_axi_wdata),
    .s_axi_wstrb          (s_axi_wstrb),
    .s_axi_wvalid         (s_axi_wvalid),
    .s_axi_wready         (s_axi_wready),
    .s_axi_bresp          (s_axi_bresp),
    .s_axi_bvalid         (s_axi_bvalid),
    .s_axi_bready         (s_axi_bready),
    .s_axi_araddr         (s_axi_araddr),
    .s_axi_arvalid        (s_axi_arvalid),
    .s_axi_arready        (s_axi_arready),
    .s_axi_rdata          (s_axi_rdata),
    .s_axi_rresp          (s_axi_rresp),
    .s_axi_rvalid         (s_axi_rvalid),
    .s_axi_rready         (s_axi_rready),
    .event_capture_input0 (event_capture_input0),
    .capture_input1       (capture_input1),
    .match_irq0           (match_irq0),
    .capture_irq1         (capture_irq1),
    .irq                  (irq)
  );
  pulse_source src (.aclk(aclk), .pin0(event_capture_input0), .pin1(capture_input1));

  // =====
  // Clock, random source, compare and verdict
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // =====
  // Bus master: hold each channel until its ready is sampled high
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk_val(s_axi_bresp, er, "bresp");
  endtask
  // Expected read result goes to the queue; the monitor compares it
  task automatic axi_rd(input logic [7:0] a, input logic care, input logic [31:0] ed,
                        input logic [1:0] er, output logic [31:0] g);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    exp_q.push_back({care, er, ed});
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    g = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  // Monitor: read results against notes, and event pulse counts
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      e_rd = exp_q.pop_front();
      chk_val(s_axi_rresp, e_rd[33:32], "rresp");
      if (e_rd[34]) chk_val(s_axi_rdata, e_rd[31:0], "rdata");
    end
    if (match_irq0 === 1'b1) n_match++;
    if (capture_irq1 === 1'b1) n_capt++;
  end
  // One counted event edge with random widths
  task automatic pulse0();
    src.pulse(0, 6 + rnd() % 4, 12 + rnd() % 4);
  endtask
  // Watchdog: the run needs well under a thousand cycles
  initial begin
    #100000;
    err_count++;
    $display("CHECK FAILED %0t watchdog", $time);
    stop_test();
  end

  // =====
  // Main sequence
  initial begin
    rs = 32'h1a;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // Reset values, then an unmapped place
    for (int a = 0; a <= 32; a += 4) axi_rd(a[7:0], 1'b1, 32'h0, `RESP_OKAY, got);
    axi_rd(8'h24, 1'b1, 32'h0, `RESP_SLVERR, got);
    axi_wr(8'h24, 32'h5, `RESP_SLVERR);
    // Event counting: first match after N+2 edges, then every N+1
    n = 2 + rnd() % 4;
    axi_wr(`OFS_CR0, n, `RESP_OKAY);
    axi_wr(`OFS_PRM, 32'h03, `RESP_OKAY);
    axi_wr(`OFS_TMC, 32'h0c, `RESP_OKAY);
    repeat (n + 1) pulse0();
    chk_val(n_match, 0, "early match");
    axi_rd(`OFS_CNT, 1'b1, n, `RESP_OKAY, got);
    src.pulse(0, 1, 12);
    axi_rd(`OFS_CNT, 1'b1, n, `RESP_OKAY, got);
    pulse0();
    chk_val(n_match, 1, "first match");
    axi_rd(`OFS_CNT, 1'b1, 0, `RESP_OKAY, got);
    repeat (n) pulse0();
    chk_val(n_match, 1, "match too soon");
    pulse0();
    chk_val(n_match, 2, "second match");
    // Sticky status drives irq only while unmasked
    chk_val(irq, 0, "masked irq");
    axi_wr(`OFS_MSK, 32'h1, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_val(irq, 1, "irq set");
    axi_wr(`OFS_STS, 32'h1, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_val(irq, 0, "irq clear");
    axi_rd(`OFS_STS, 1'b1, 0, `RESP_OKAY, got);
    // Pulse-width measurement: rise to reg0, fall to reg1
    axi_wr(`OFS_MSK, 32'h0, `RESP_OKAY);
    axi_wr(`OFS_TMC, 32'h0, `RESP_OKAY);
    axi_wr(`OFS_TOC, 32'h13, `RESP_OKAY);
    axi_wr(`OFS_PRM, 32'h00, `RESP_OKAY);
    axi_wr(`OFS_CRC, 32'h07, `RESP_OKAY);
    axi_wr(`OFS_TMC, 32'h0a, `RESP_OKAY);
    // Even width: both edges meet the same tick phase, so the count is exact
    h = 2 * (4 + rnd() % 4);
    repeat (2) src.pulse(0, h, 16);
    chk_val(n_capt, 2, "captures");
    chk_val(n_match, 2, "reverse phase match");
    axi_rd(`OFS_CR0, 1'b0, 0, `RESP_OKAY, c0);
    axi_rd(`OFS_CR1, 1'b0, 0, `RESP_OKAY, got);
    chk_val(got - c0, h / PRE, "high width");
    src.pulse(1, 8, 16);
    chk_val(n_match, 3, "input1 match");
    chk_val(n_capt, 2, "input1 capture");
    // Input1 on both edges captures into both registers in free run
    axi_wr(`OFS_CRC, 32'h01, `RESP_OKAY);
    axi_wr(`OFS_PRM, 32'h60, `RESP_OKAY);
    axi_wr(`OFS_TMC, 32'h04, `RESP_OKAY);
    src.pulse(1, 8, 16);
    chk_val(n_match, 5, "input1 both-edge match");
    chk_val(n_capt, 4, "input1 both-edge capture");
    axi_rd(`OFS_CR0, 1'b0, 0, `RESP_OKAY, c0);
    axi_rd(`OFS_CR1, 1'b0, 0, `RESP_OKAY, got);
    chk_val(got - c0, 0, "same-edge captures");
    stop_test();
  end
endmodule // timer_event_count_capture_bench

bind timer_event_count_capture timer_chk u_chk (
  .aclk                 (aclk),
  .aresetn              (aresetn),
  .s_axi_awvalid        (s_axi_awvalid),
  .s_axi_awready        (s_axi_awready),
  .s_axi_wvalid         (s_axi_wvalid),
  .s_axi_wready         (s_axi_wready),
  .s_axi_bvalid         (s_axi_bvalid),
  .s_axi_bready         (s_axi_bready),
  .s_axi_arvalid        (s_axi_arvalid),
  .s_axi_arready        (s_axi_arready),
  .s_axi_rvalid         (s_axi_rvalid),
  .s_axi_rready         (s_axi_rready),
  .event_capture_input0 (event_capture_input0),
  .match_irq0           (match_irq0),
  .capture_irq1         (capture_irq1)
);
`default_nettype wire

// *** sim/timer_event_count_capture_sva.sv ***
// Checker for the timer slice: bus handshakes and event pulses.
// Sees only top-level ports; bound from the bench top file.
`timescale 1ns/10ps
`default_nettype none
module timer_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic event_capture_input0,
  input wire logic match_irq0,
  input wire logic capture_irq1
);
  // =====
  // Bus steps, all on aclk
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_wr_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  chk_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data missing");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  chk_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  // =====
  // Event pulses last one cycle; a capture needs a settled low input
  chk_match_pulse: assert property (match_irq0 |=> !match_irq0)
    else $error("match pulse too long");
  chk_capt_pulse: assert property (capture_irq1 |=> !capture_irq1)
    else $error("capture pulse too long");
  chk_capt_filter: assert property (capture_irq1 |->
    !$past(event_capture_input0, 2) && !$past(event_capture_input0, 3))
    else $error("capture without settled input");
endmodule // timer_chk
`default_nettype wire
